// ==== src/rsc_pkg.sv ====
// Package for the reset strap configuration capture block.
// Assumes one 20 MHz clock and an AHB-Lite register bus.
package rsc_pkg;

	// ********************************************************
	// Register map
	// ********************************************************
	localparam logic [7:0] RSC_OFS_MEM_CFG    = 8'h00;
	localparam logic [7:0] RSC_OFS_TEST_CLK   = 8'h04;
	localparam logic [7:0] RSC_OFS_MEM_TIMING = 8'h08;
	localparam logic [7:0] RSC_OFS_SERIAL     = 8'h0c;
	localparam logic [7:0] RSC_OFS_STATUS     = 8'h10;
	localparam int         RSC_NUM_CFG        = 4;
	localparam int         RSC_STRAP_W        = 29;

	// Value after reset: every strap bit reads 1, bits with no pin read 0
	localparam logic [31:0] RSC_CFG_RST = 32'h1fffffff;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int RSC_PAGE_LSB     = 2;
	localparam int RSC_SIZE_LSB     = 5;
	localparam int RSC_SCAN_BIT     = 1;
	localparam int RSC_CLKSRC_BIT   = 3;
	localparam int RSC_PANEL_LSB    = 5;
	localparam int RSC_STRETCH_LSB  = 0;
	localparam int RSC_ROW_LOW_BIT  = 2;
	localparam int RSC_ROW_PRE_BIT  = 3;
	localparam int RSC_MEM_TYPE_BIT = 6;
	localparam int RSC_SIO_ADDR_BIT = 1;
	localparam int RSC_SIO_TYPE_BIT = 2;

	// ********************************************************
	// Field codes and decoded values
	// ********************************************************
	localparam logic [1:0]  RSC_PAGE_EDO1_C = 2'h0;
	localparam logic [1:0]  RSC_PAGE_EDO2_C = 2'h2;
	localparam logic [1:0]  RSC_PAGE_FAST_C = 2'h3;
	localparam logic [2:0]  RSC_SIZE_4M_C   = 3'h0;
	localparam logic [2:0]  RSC_SIZE_2M_C   = 3'h4;
	localparam logic [2:0]  RSC_SIZE_1M_C   = 3'h6;
	localparam logic [12:0] RSC_KB_4M       = 13'h1000;
	localparam logic [12:0] RSC_KB_2M       = 13'h0800;
	localparam logic [12:0] RSC_KB_1M       = 13'h0400;
	// Stretch in tenths of a nanosecond
	localparam logic [6:0]  RSC_STRETCH_00  = 7'h41;
	localparam logic [6:0]  RSC_STRETCH_01  = 7'h32;
	localparam logic [6:0]  RSC_STRETCH_10  = 7'h23;
	localparam logic [6:0]  RSC_STRETCH_11  = 7'h00;
	// Row strobe times in half memory clocks
	localparam logic [3:0]  RSC_ROW_LOW_0   = 4'h9;
	localparam logic [3:0]  RSC_ROW_LOW_1   = 4'h7;
	localparam logic [3:0]  RSC_ROW_PRE_0   = 4'h7;
	localparam logic [3:0]  RSC_ROW_PRE_1   = 4'h5;
	localparam logic [19:0] RSC_SIO_PORT_0  = 20'h000e8;
	localparam logic [19:0] RSC_SIO_PORT_1  = 20'h000e2;
	localparam logic [15:0] RSC_SIO_MMIO    = 16'hff20;

	typedef enum logic [1:0] {
		RSC_PAGE_EDO1,
		RSC_PAGE_EDO2,
		RSC_PAGE_FAST,
		RSC_PAGE_RSVD
	} rsc_page_t;

	typedef struct packed {
		rsc_page_t   page_mode;
		logic [12:0] mem_size_kb;
		logic        mem_cfg_ok;
		logic        mem_type_x16;
		logic        clk_internal;
		logic [2:0]  panel_type;
		logic [6:0]  stretch_100ps;
		logic [3:0]  row_low_half;
		logic [3:0]  row_pre_half;
		logic [19:0] serial_io_addr;
		logic        serial_io_en;
		logic [15:0] serial_mmio_ofs;
		logic        scan_mode;
	} rsc_cfg_t;

	typedef struct packed {
		logic       active;
		logic       write;
		logic [7:0] addr;
	} rsc_bus_req_t;

endpackage

// ==== src/rsc_config_capture.sv ====
// Reset strap capture, configuration registers and connectivity test.
// Assumes an AHB-Lite master, strap pins settled around reset release,
// and pad logic that resolves pins from the active-low enables.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module rsc_config_capture
	import rsc_pkg::*;
#(
	parameter int TEST_W = 16
) (
	input  wire logic                   clk_in,
	input  wire logic                   sys_rst_in,
	input  wire logic                   hsel_in,
	input  wire logic [31:0]            haddr_in,
	input  wire logic [1:0]             htrans_in,
	input  wire logic                   hwrite_in,
	input  wire logic [2:0]             hsize_in,
	input  wire logic [31:0]            hwdata_in,
	input  wire logic                   hready_in,
	output logic                        hreadyout_out,
	output logic [31:0]                 hrdata_out,
	output logic                        hresp_out,
	input  wire logic [RSC_STRAP_W-1:0] pixel_strap_pins_in,
	input  wire logic [RSC_STRAP_W-1:0] pixel_value_in,
	output logic      [RSC_STRAP_W-1:0] pixel_strap_pins_out,
	output logic      [RSC_STRAP_W-1:0] pixel_strap_pins_oe_n_out,
	input  wire logic                   mem_read_en_n_in,
	output logic                        mem_read_en_n_out,
	output logic                        mem_read_en_oe_n_out,
	input  wire logic [TEST_W-1:0]      test_pins_in,
	output logic                        scan_result_out,
	output rsc_cfg_t                    cfg_out
);

	// ********************************************************
	// Declarations
	// ********************************************************
	logic [7:0]   cfg_reg [0:RSC_NUM_CFG-1];
	logic         rst_d_reg;
	logic         capture;
	logic [31:0]  strap_word;
	rsc_bus_req_t req_reg;
	logic         addr_phase;
	logic         wr_phase;
	logic [1:0]   rd_idx;
	logic [31:0]  rd_next;
	logic [7:0]   status_next;
	rsc_cfg_t     cfg_next;
	logic         scan_sel;

	// ********************************************************
	// Strap capture at reset release
	// ********************************************************
	always_ff @(posedge clk_in) begin
		rst_d_reg <= sys_rst_in;
	end

	assign capture    = rst_d_reg && !sys_rst_in;
	// Unstrapped pins sit low on the pull-down and latch as 1
	assign strap_word = {3'h0, ~pixel_strap_pins_in};

	// ********************************************************
	// Bus slave
	// ********************************************************
	assign addr_phase = hsel_in && htrans_in[1] && hready_in;
	assign wr_phase   = req_reg.active && req_reg.write;
	assign rd_idx     = haddr_in[3:2];

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			req_reg <= '0;
		end else begin
			req_reg.active <= addr_phase;
			req_reg.write  <= hwrite_in;
			req_reg.addr   <= haddr_in[7:0];
		end
	end

	generate
		for (genvar k = 0; k < RSC_NUM_CFG; k++) begin : g_cfg
			always_ff @(posedge clk_in) begin
				if (sys_rst_in) begin
					cfg_reg[k] <= RSC_CFG_RST[8*k +: 8];
				end else if (capture) begin
					cfg_reg[k] <= strap_word[8*k +: 8];
				end else if (wr_phase && req_reg.addr == 8'(4 * k)) begin
					cfg_reg[k] <= hwdata_in[7:0];
				end
			end
		end
	endgenerate

	always_comb begin
		status_next = {7'h00, cfg_next.mem_cfg_ok};
		rd_next     = 32'h00000000;
		if (haddr_in[7:0] == RSC_OFS_STATUS) begin
			rd_next = {24'h000000, status_next};
		end else if (haddr_in[7:4] == 4'h0 && haddr_in[1:0] == 2'h0) begin
			// Forward a write still in its data phase to the same register
			if (wr_phase && req_reg.addr == haddr_in[7:0]) begin
				rd_next = {24'h000000, hwdata_in[7:0]};
			end else begin
				rd_next = {24'h000000, cfg_reg[rd_idx]};
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			hrdata_out <= 32'h00000000;
		end else if (addr_phase && !hwrite_in) begin
			hrdata_out <= rd_next;
		end
	end

	always_ff @(posedge clk_in) begin
		hreadyout_out <= 1'b1;
		hresp_out     <= 1'b0;
	end

	// ********************************************************
	// Field decode
	// ********************************************************
	always_comb begin
		cfg_next = '0;
		case (cfg_reg[0][RSC_PAGE_LSB +: 2])
			RSC_PAGE_EDO1_C: cfg_next.page_mode = RSC_PAGE_EDO1;
			RSC_PAGE_EDO2_C: cfg_next.page_mode = RSC_PAGE_EDO2;
			RSC_PAGE_FAST_C: cfg_next.page_mode = RSC_PAGE_FAST;
			default:         cfg_next.page_mode = RSC_PAGE_RSVD;
		endcase
		cfg_next.mem_type_x16 = cfg_reg[2][RSC_MEM_TYPE_BIT];
		case (cfg_reg[0][RSC_SIZE_LSB +: 3])
			RSC_SIZE_4M_C: begin
				cfg_next.mem_size_kb = RSC_KB_4M;
				cfg_next.mem_cfg_ok  = !cfg_next.mem_type_x16;
			end
			RSC_SIZE_2M_C: begin
				cfg_next.mem_size_kb = RSC_KB_2M;
				cfg_next.mem_cfg_ok  = 1'b1;
			end
			RSC_SIZE_1M_C: begin
				cfg_next.mem_size_kb = RSC_KB_1M;
				cfg_next.mem_cfg_ok  = cfg_next.mem_type_x16;
			end
			default: begin
				cfg_next.mem_size_kb = 13'h0000;
				cfg_next.mem_cfg_ok  = 1'b0;
			end
		endcase
		cfg_next.scan_mode    = !cfg_reg[1][RSC_SCAN_BIT];
		cfg_next.clk_internal = cfg_reg[1][RSC_CLKSRC_BIT];
		cfg_next.panel_type   = cfg_reg[1][RSC_PANEL_LSB +: 3];
		case (cfg_reg[2][RSC_STRETCH_LSB +: 2])
			2'h0:    cfg_next.stretch_100ps = RSC_STRETCH_00;
			2'h1:    cfg_next.stretch_100ps = RSC_STRETCH_01;
			2'h2:    cfg_next.stretch_100ps = RSC_STRETCH_10;
			default: cfg_next.stretch_100ps = RSC_STRETCH_11;
		endcase
		cfg_next.row_low_half = cfg_reg[2][RSC_ROW_LOW_BIT] ? RSC_ROW_LOW_1
			: RSC_ROW_LOW_0;
		cfg_next.row_pre_half = cfg_reg[2][RSC_ROW_PRE_BIT] ? RSC_ROW_PRE_1
			: RSC_ROW_PRE_0;
		cfg_next.serial_io_addr = cfg_reg[3][RSC_SIO_ADDR_BIT] ? RSC_SIO_PORT_1
			: RSC_SIO_PORT_0;
		cfg_next.serial_io_en    = !cfg_reg[3][RSC_SIO_TYPE_BIT];
		cfg_next.serial_mmio_ofs = RSC_SIO_MMIO;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cfg_out <= '0;
		end else begin
			cfg_out <= cfg_next;
		end
	end

	// ********************************************************
	// Pin control and connectivity test
	// ********************************************************
	// Fresh strap decides at capture: no pin drives for a cycle in test mode
	assign scan_sel = capture ? !strap_word[8 + RSC_SCAN_BIT] : cfg_next.scan_mode;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			pixel_strap_pins_oe_n_out <= '1;
			pixel_strap_pins_out      <= '0;
			mem_read_en_n_out         <= 1'b1;
			mem_read_en_oe_n_out      <= 1'b0;
		end else if (scan_sel) begin
			pixel_strap_pins_oe_n_out <= '1;
			pixel_strap_pins_out      <= '0;
			mem_read_en_n_out         <= 1'b1;
			mem_read_en_oe_n_out      <= 1'b1;
		end else begin
			pixel_strap_pins_oe_n_out <= '0;
			pixel_strap_pins_out      <= pixel_value_in;
			mem_read_en_n_out         <= mem_read_en_n_in;
			mem_read_en_oe_n_out      <= 1'b0;
		end
	end

	// Parity flips once per input pulled low, whatever the order
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !scan_sel) begin
			scan_result_out <= 1'b0;
		end else begin
			scan_result_out <= ^{test_pins_in, pixel_strap_pins_in};
		end
	end

	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge clk_in);
	endclocking

	default disable iff (sys_rst_in);

	sequence reset_release_s;
		$fell(sys_rst_in);
	endsequence

	sequence cfg_write_s;
		wr_phase && !capture && req_reg.addr == RSC_OFS_TEST_CLK;
	endsequence

	sequence map_read_s;
		addr_phase && !hwrite_in && haddr_in[7:0] == RSC_OFS_MEM_TIMING
			&& !(wr_phase && req_reg.addr == RSC_OFS_MEM_TIMING);
	endsequence

	reset_pins_float_a : assert property (disable iff (1'b0)
		sys_rst_in |=> (&pixel_strap_pins_oe_n_out) && mem_read_en_n_out
			&& !mem_read_en_oe_n_out)
		else $error("Pins not floated with read enable high in reset");

	reset_defaults_a : assert property (disable iff (1'b0)
		sys_rst_in |=> cfg_reg[0] == 8'hff && cfg_reg[1] == 8'hff
			&& cfg_reg[3] == 8'h1f && cfg_out == '0)
		else $error("Registers not at defaults during reset");

	strap_capture_a : assert property (
		reset_release_s |=> cfg_reg[0] == ~$past(pixel_strap_pins_in[7:0])
			&& cfg_reg[1] == ~$past(pixel_strap_pins_in[15:8])
			&& cfg_reg[2] == ~$past(pixel_strap_pins_in[23:16])
			&& cfg_reg[3] == {3'h0, ~$past(pixel_strap_pins_in[28:24])})
		else $error("Straps not captured inverted at reset release");

	plain_write_a : assert property (
		cfg_write_s |=> cfg_reg[1] == $past(hwdata_in[7:0]))
		else $error("Written value not stored unchanged");

	plain_read_a : assert property (
		map_read_s |=> hrdata_out == {24'h000000, $past(cfg_reg[2])})
		else $error("Read value differs from stored value");

	page_decode_a : assert property (
		!sys_rst_in && cfg_reg[0][3:2] == 2'h3 ##1 cfg_reg[0][3:2] == 2'h3
			|-> cfg_out.page_mode == RSC_PAGE_FAST)
		else $error("Fast page code not decoded");

	size_decode_a : assert property (
		cfg_reg[0][7:5] == 3'h6 && cfg_reg[2][6]
			|=> cfg_out.mem_size_kb == RSC_KB_1M && cfg_out.mem_cfg_ok)
		else $error("One megabyte size not decoded");

	stretch_decode_a : assert property (
		cfg_reg[2][1:0] == 2'h0 |=> cfg_out.stretch_100ps == RSC_STRETCH_00)
		else $error("Largest stretch not decoded");

	serial_map_a : assert property (
		cfg_reg[3][2:1] == 2'h1 |=> cfg_out.serial_io_addr == RSC_SIO_PORT_1
			&& cfg_out.serial_io_en)
		else $error("Serial port mapping wrong");

	scan_inputs_a : assert property (
		!cfg_reg[1][1] |=> (&pixel_strap_pins_oe_n_out) && mem_read_en_oe_n_out)
		else $error("A pin is driven in test mode");

	scan_parity_a : assert property (
		!cfg_reg[1][1] |=> scan_result_out
			== ^$past({test_pins_in, pixel_strap_pins_in}))
		else $error("Scan result is not the input parity");

	// ********************************************************
	// Decode, bus and pin assertions
	// ********************************************************
	sequence running_s;
		!sys_rst_in && !capture;
	endsequence

	sequence normal_mode_s;
		!sys_rst_in && !capture && cfg_reg[1][RSC_SCAN_BIT];
	endsequence

	sequence status_read_s;
		addr_phase && !hwrite_in && haddr_in[7:0] == RSC_OFS_STATUS;
	endsequence

	clock_select_a : assert property (
		running_s |=> cfg_out.clk_internal == $past(cfg_reg[1][RSC_CLKSRC_BIT]))
		else $error("Clock source bit not decoded");

	panel_type_a : assert property (
		running_s |=> cfg_out.panel_type == $past(cfg_reg[1][RSC_PANEL_LSB +: 3]))
		else $error("Panel type field not passed through");

	scan_select_a : assert property (
		running_s |=> cfg_out.scan_mode == !$past(cfg_reg[1][RSC_SCAN_BIT]))
		else $error("Scan select bit not decoded");

	row_timing_a : assert property (
		!sys_rst_in && cfg_reg[2][3:2] == 2'h0 |=> cfg_out.row_low_half == RSC_ROW_LOW_0
			&& cfg_out.row_pre_half == RSC_ROW_PRE_0)
		else $error("Slow row strobe timing not decoded");

	serial_mmio_a : assert property (
		!sys_rst_in && cfg_reg[3][RSC_SIO_TYPE_BIT] |=> !cfg_out.serial_io_en
			&& cfg_out.serial_mmio_ofs == RSC_SIO_MMIO)
		else $error("Serial port not limited to memory map");

	reserved_size_a : assert property (
		!sys_rst_in && cfg_reg[0][7:5] == 3'h7 |=> cfg_out.mem_size_kb == 13'h0000
			&& !cfg_out.mem_cfg_ok)
		else $error("Reserved size code not flagged");

	status_size_a : assert property (
		status_read_s ##0 cfg_reg[0][7:5] == 3'h4 |=> hrdata_out == 32'h00000001)
		else $error("Two megabyte size not reported valid");

	test_release_a : assert property (
		reset_release_s ##0 pixel_strap_pins_in[8 + RSC_SCAN_BIT]
			|=> (&pixel_strap_pins_oe_n_out) && mem_read_en_oe_n_out)
		else $error("A pin is driven after release into test mode");

	normal_drive_a : assert property (
		normal_mode_s |=> pixel_strap_pins_oe_n_out == '0
			&& pixel_strap_pins_out == $past(pixel_value_in))
		else $error("Pixel data not driven in normal operation");

	read_en_follow_a : assert property (
		normal_mode_s |=> !mem_read_en_oe_n_out
			&& mem_read_en_n_out == $past(mem_read_en_n_in))
		else $error("Read enable not driven in normal operation");

	scan_idle_a : assert property (
		normal_mode_s |=> !scan_result_out)
		else $error("Scan result active outside test mode");

	regs_hold_a : assert property (
		running_s ##0 !wr_phase |=> $stable(cfg_reg[0]) && $stable(cfg_reg[1])
			&& $stable(cfg_reg[2]) && $stable(cfg_reg[3]))
		else $error("Register changed without a write");

	read_hold_a : assert property (
		!sys_rst_in && !(addr_phase && !hwrite_in) |=> $stable(hrdata_out))
		else $error("Read data changed without a read");

	bus_okay_a : assert property (
		!sys_rst_in |=> hreadyout_out && !hresp_out)
		else $error("Bus not ready with an okay response");

endmodule

// ==== verification/rsc_board.sv ====
// Board model: strap resistors on the pixel pins and a connectivity tester.
// Assumes active-low pin enables from the design; tester drives when enabled.
`timescale 1ns/1ns
module rsc_board
	import rsc_pkg::*;
#(
	parameter int TEST_W = 16
) (
	input  wire logic [RSC_STRAP_W-1:0]        pullup_mask_in,
	input  wire logic                          tester_en_in,
	input  wire logic [TEST_W+RSC_STRAP_W-1:0] tester_pat_in,
	input  wire logic [RSC_STRAP_W-1:0]        pin_drive_in,
	input  wire logic [RSC_STRAP_W-1:0]        pin_oe_n_in,
	output logic      [RSC_STRAP_W-1:0]        pins_out,
	output logic      [TEST_W-1:0]             test_pins_out
);
	// ********************************************************
	// Pin resolution
	// ********************************************************
	always_comb begin
		for (int i = 0; i < RSC_STRAP_W; i++) begin
			if (tester_en_in)
				pins_out[i] = tester_pat_in[i];
			else if (!pin_oe_n_in[i])
				pins_out[i] = pin_drive_in[i];
			else
				pins_out[i] = pullup_mask_in[i]; // Pull-up or weak pull-down
		end
		test_pins_out = tester_en_in ? tester_pat_in[TEST_W+RSC_STRAP_W-1:RSC_STRAP_W] : '1;
	end
endmodule

// ==== verification/reset_strap_config_capture_test.sv ====
// Testbench for the strap capture block: AHB-Lite tasks and pin scenarios.
// Assumes the board model and a zero-wait-state slave.
`timescale 1ns/1ns
module reset_strap_config_capture_test;
	import rsc_pkg::*;
	localparam int          TEST_W = 16;
	localparam logic [28:0] MASK_A = 29'h12345481;
	localparam logic [28:0] MASK_B = 29'h12345681;
	localparam rsc_page_t   PAGES[4] = '{RSC_PAGE_EDO1, RSC_PAGE_RSVD, RSC_PAGE_EDO2, RSC_PAGE_FAST};
	localparam logic [2:0]  SIZES[4] = '{3'h0, 3'h4, 3'h6, 3'h7};
	localparam logic [12:0] KBS[4]   = '{RSC_KB_4M, RSC_KB_2M, RSC_KB_1M, 13'h0};
	localparam logic [6:0]  STR[4]   = '{RSC_STRETCH_00, RSC_STRETCH_01, RSC_STRETCH_10, RSC_STRETCH_11};
	logic                   clk_in = 1'b0, sys_rst_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0;
	logic                   tester_en = 1'b0;
	logic [31:0]            haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out;
	logic [1:0]             htrans_in = 2'h0;
	logic                   hreadyout_out, hresp_out, rd_en_n, rd_en_oe_n, scan_result_out;
	logic [28:0]            pins, pin_drv, pin_oe_n, pullup_mask = 29'h0;
	logic [28:0]            pix_val = 29'h0a5a5a5a;
	logic [TEST_W+28:0]     tpat = 45'h1fffffffffff;
	logic [TEST_W-1:0]      test_pins;
	rsc_cfg_t               cfg_out;
	int                     num_errors = 0, comparisons = 0;

	always #25 clk_in = ~clk_in;

	rsc_config_capture #(.TEST_W(TEST_W)) u_rsc_config_capture (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
		.htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
		.hready_in(hreadyout_out), .hreadyout_out(hreadyout_out), .hrdata_out(hrdata_out),
		.hresp_out(hresp_out), .pixel_strap_pins_in(pins), .pixel_value_in(pix_val),
		.pixel_strap_pins_out(pin_drv), .pixel_strap_pins_oe_n_out(pin_oe_n),
		.mem_read_en_n_in(1'b1), .mem_read_en_n_out(rd_en_n),
		.mem_read_en_oe_n_out(rd_en_oe_n), .test_pins_in(test_pins),
		.scan_result_out(scan_result_out), .cfg_out(cfg_out));

	rsc_board #(.TEST_W(TEST_W)) u_rsc_board (
		.pullup_mask_in(pullup_mask), .tester_en_in(tester_en), .tester_pat_in(tpat),
		.pin_drive_in(pin_drv), .pin_oe_n_in(pin_oe_n), .pins_out(pins),
		.test_pins_out(test_pins));

	// ********************************************************
	// Tasks
	// ********************************************************
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge clk_in);
		while (hreadyout_out !== 1'b1) begin
			n++;
			if (n > 50) begin
				num_errors++;
				$display("mismatch hready expected 1 seen %b", hreadyout_out);
				conclude();
			end
			@(posedge clk_in);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		hsel_in <= 1'b1;
		haddr_in <= {24'h0, a};
		hwrite_in <= wr;
		htrans_in <= 2'h2;
		wait_rdy();
		htrans_in <= 2'h0;
		if (wr)
			hwdata_in <= d;
		wait_rdy();
		q = hrdata_out;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(name, exp, q);
		chk("hresp", 32'h0, {31'h0, hresp_out});
	endtask

	task automatic do_reset(input logic [28:0] mask);
		pullup_mask <= mask;
		sys_rst_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		chk("pin_oe_n_reset", 32'h1fffffff, {3'h0, pin_oe_n});
		chk("read_en_reset", 32'h1, {31'h0, rd_en_n & ~rd_en_oe_n});
		sys_rst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
	endtask

	task automatic chk_straps(input logic [28:0] mask);
		logic [7:0] e;
		for (int k = 0; k < 4; k++) begin
			e = (k == 3) ? {3'h0, ~mask[28:24]} : ~mask[8*k +: 8];
			rd_chk("strap_reg", 8'(4 * k), {24'h0, e});
		end
	endtask

	// ********************************************************
	// Tests
	// ********************************************************
	initial begin
		do_reset(MASK_A);
		chk_straps(MASK_A);
		chk("pin_oe_n_normal", 32'h0, {3'h0, pin_oe_n});
		chk("scan_normal", 32'h0, {31'h0, scan_result_out});
		chk("pin_drv_normal", {3'h0, pix_val}, {3'h0, pin_drv});
		chk("scan_mode_normal", 32'h0, {31'h0, cfg_out.scan_mode});
		$display("test strap_capture done");
		wr(RSC_OFS_MEM_CFG, 32'ha5);
		wr(RSC_OFS_TEST_CLK, 32'hfa);
		wr(RSC_OFS_MEM_TIMING, 32'h5a);
		wr(RSC_OFS_SERIAL, 32'hc3);
		rd_chk("mem_cfg_rw", RSC_OFS_MEM_CFG, 32'ha5);
		rd_chk("test_clk_rw", RSC_OFS_TEST_CLK, 32'hfa);
		rd_chk("timing_rw", RSC_OFS_MEM_TIMING, 32'h5a);
		rd_chk("serial_rw", RSC_OFS_SERIAL, 32'hc3);
		rd_chk("unmapped", 8'h14, 32'h0);
		$display("test register_rw done");
		for (int i = 0; i < 4; i++) begin
			wr(RSC_OFS_MEM_CFG, {24'h0, SIZES[i], 1'b0, 2'(i), 2'h0});
			wr(RSC_OFS_TEST_CLK, {24'h0, 3'(i), 1'b0, i[0], 3'h2});
			wr(RSC_OFS_MEM_TIMING, {24'h0, 1'b0, i[1], 2'h0, i[0], i[0], 2'(i)});
			wr(RSC_OFS_SERIAL, {24'h0, 5'h0, i[1], i[0], 1'b0});
			repeat (2) @(posedge clk_in);
			chk("page_mode", {30'h0, PAGES[i]}, {30'h0, cfg_out.page_mode});
			chk("mem_size", {19'h0, KBS[i]}, {19'h0, cfg_out.mem_size_kb});
			chk("stretch", {25'h0, STR[i]}, {25'h0, cfg_out.stretch_100ps});
			chk("row_times", {24'h0, i[0] ? 8'h75 : 8'h97},
				{24'h0, cfg_out.row_low_half, cfg_out.row_pre_half});
			chk("serial_io", {11'h0, i[0] ? RSC_SIO_PORT_1 : RSC_SIO_PORT_0, ~i[1]},
				{11'h0, cfg_out.serial_io_addr, cfg_out.serial_io_en});
			chk("clk_panel_type", {27'h0, 3'(i), i[0], i[1]}, {27'h0, cfg_out.panel_type,
				cfg_out.clk_internal, cfg_out.mem_type_x16});
			chk("serial_mmio", {16'h0, RSC_SIO_MMIO},
				{16'h0, cfg_out.serial_mmio_ofs});
			rd_chk("status", RSC_OFS_STATUS, {31'h0, i != 3});
		end
		$display("test decode done");
		do_reset(MASK_B);
		chk_straps(MASK_B);
		chk("pin_oe_n_test", 32'h1fffffff, {3'h0, pin_oe_n});
		chk("read_en_oe_test", 32'h1, {31'h0, rd_en_oe_n});
		chk("scan_mode_test", 32'h1, {31'h0, cfg_out.scan_mode});
		tester_en <= 1'b1;
		repeat (2) @(posedge clk_in);
		chk("scan_all_high", {31'h0, ^tpat}, {31'h0, scan_result_out});
		for (int i = TEST_W + 28; i >= 0; i--) begin
			tpat[i] <= 1'b0;
			repeat (2) @(posedge clk_in);
			chk("scan_step", {31'h0, ^tpat}, {31'h0, scan_result_out});
		end
		$display("test connectivity done");
		conclude();
	end
endmodule
